// ==== common/cscs_pkg.sv ====
// Purpose: Shared constants and types for the card socket cycle engine
// Assumes: 250 MHz system clock, two sockets, 16-bit card data path
// Notes: Strobe phase lengths are fixed figures converted to clock counts here

package cscs_pkg;

  // ************************************************
  // Clock and cycle phase timing
  // ************************************************
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SETUP_NS = 8;
  localparam int unsigned ACTIVE_NS = 40;
  localparam int unsigned RECOVER_NS = 8;
  // Least times: round up, never below one cycle
  localparam int unsigned SETUP_CYC_RAW = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACTIVE_CYC_RAW = (ACTIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RECOVER_CYC_RAW =
    (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] SETUP_CYC = (SETUP_CYC_RAW < 1) ? 4'h1 : 4'(SETUP_CYC_RAW);
  localparam logic [3:0] ACTIVE_CYC = (ACTIVE_CYC_RAW < 1) ? 4'h1 : 4'(ACTIVE_CYC_RAW);
  localparam logic [3:0] RECOVER_CYC = (RECOVER_CYC_RAW < 1) ? 4'h1 : 4'(RECOVER_CYC_RAW);

  // ************************************************
  // Structure sizes and reset values
  // ************************************************
  localparam int unsigned NUM_SOCKETS = 2;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CMD_W = 24;
  localparam logic [1:0] SOCK_IDLE = 2'h3;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // ************************************************
  // Cycle kinds and access widths
  // ************************************************
  typedef enum logic [2:0] {
    CSCS_CMEM_RD = 3'b000,
    CSCS_CMEM_WR = 3'b001,
    CSCS_ATTR_RD = 3'b010,
    CSCS_ATTR_WR = 3'b011,
    CSCS_IO_RD = 3'b100,
    CSCS_IO_WR = 3'b101,
    CSCS_DMA_RD = 3'b110,
    CSCS_DMA_WR = 3'b111
  } cscs_kind_t;

  typedef enum logic [1:0] {
    CSCS_BYTE = 2'b00,
    CSCS_WORD = 2'b01,
    CSCS_ODD = 2'b10,
    CSCS_RSVD = 2'b11
  } cscs_width_t;

  typedef struct packed {
    cscs_kind_t kind;
    cscs_width_t width;
    logic socket;
    logic lsb;
    logic tc;
    logic [15:0] wdata;
  } cscs_cmd_t;

  typedef enum logic [1:0] {
    CSCS_IDLE = 2'b00,
    CSCS_SETUP = 2'b01,
    CSCS_ACTIVE = 2'b10,
    CSCS_RECOVER = 2'b11
  } cscs_state_t;

endpackage

// ==== common/cscs_stream_if.sv ====
// Purpose: Valid/ready carrier for queued cycle commands
// Assumes: Single clock domain
// Notes: Word width is a parameter so the queue stays generic
`timescale 1ns/1ps

interface cscs_stream_if #(parameter int unsigned W = 24);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== hw/cscs_fifo.sv ====
// Purpose: Parameterised first-in first-out queue with valid/ready on both sides
// Assumes: Synchronous active-low reset, depth a power of two
// Notes: Read data is taken straight from the array at the read pointer
`timescale 1ns/1ps

module cscs_fifo #(
  parameter int unsigned W = 24,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  cscs_stream_if.src out
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic push, pop;
  logic in_ready_ff, nxt_in_ready;

  // ************************************************
  // Pointer and level control
  // ************************************************
  always_comb begin
    push = in_valid && in_ready;
    pop = out.valid && out.ready;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    nxt_in_ready = (nxt_count != (AW+1)'(DEPTH));
  end

  // Ready is registered from the next level, so it stays exact and leaves from a flop
  assign in_ready = in_ready_ff;
  assign out.valid = (count_ff != '0);
  assign out.data = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b1;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      in_ready_ff <= nxt_in_ready;
    end
  end

  // Storage needs no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

endmodule

// ==== hw/cscs_socket_host.sv ====
// Purpose: Card socket cycle engine driving strobes, card enables and byte lanes
// Assumes: Commands arrive on a valid/ready port and are queued sixteen deep
// Notes: One cycle runs at a time; read data returns as a one-cycle pulse
`timescale 1ns/1ps

module cscs_socket_host (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire cscs_pkg::cscs_kind_t req_kind,
  input wire cscs_pkg::cscs_width_t req_width,
  input wire logic req_socket,
  input wire logic req_lsb,
  input wire logic req_tc,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic busy,
  output logic [1:0] space_select,
  output logic [1:0] high_lane_card_enable_n,
  output logic [1:0] low_lane_card_enable_n,
  output logic address_lsb,
  output logic mem_read_strobe_n,
  output logic mem_write_strobe_n,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic dma_grant,
  input wire logic [7:0] high_data_lane_in,
  output logic [7:0] high_data_lane_out,
  output logic high_data_lane_oe,
  input wire logic [7:0] low_data_lane_in,
  output logic [7:0] low_data_lane_out,
  output logic low_data_lane_oe
);

  import cscs_pkg::*;

  // ************************************************
  // Command queue
  // ************************************************
  cscs_stream_if #(.W(CMD_W)) q_if ();
  cscs_cmd_t req_cmd;
  cscs_cmd_t q_cmd;

  assign req_cmd = '{kind: req_kind, width: req_width, socket: req_socket, lsb: req_lsb,
                     tc: req_tc, wdata: req_wdata};
  assign q_cmd = cscs_cmd_t'(q_if.data);

  // Requester stalls on the queue's own ready, so a slow card backs up to the source
  cscs_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(CMD_W'(req_cmd)),
    .out(q_if.src)
  );

  // ************************************************
  // State and pin registers
  // ************************************************
  cscs_state_t state_ff, nxt_state;
  cscs_cmd_t cmd_ff, nxt_cmd;
  logic [3:0] cnt_ff, nxt_cnt;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [15:0] rsp_data_ff, nxt_rsp_data;
  logic busy_ff, nxt_busy;
  logic [1:0] sel_ff, nxt_sel;
  logic [1:0] ceh_ff, nxt_ceh;
  logic [1:0] cel_ff, nxt_cel;
  logic lsb_ff, nxt_lsb;
  logic mrd_ff, nxt_mrd;
  logic mwr_ff, nxt_mwr;
  logic iord_ff, nxt_iord;
  logic iowr_ff, nxt_iowr;
  logic dma_grant_ff, nxt_dma_grant;
  logic [7:0] hout_ff, nxt_hout;
  logic hoe_ff, nxt_hoe;
  logic [7:0] lout_ff, nxt_lout;
  logic loe_ff, nxt_loe;

  // Decoded view of the command in flight
  logic is_rd, is_io, is_attr, is_dma;
  logic want_hi, want_lo;
  logic [7:0] hi_byte, lo_byte;

  assign q_if.ready = (state_ff == CSCS_IDLE);

  // ************************************************
  // Access decode
  // ************************************************
  always_comb begin
    is_io = (cmd_ff.kind == CSCS_IO_RD) || (cmd_ff.kind == CSCS_IO_WR);
    is_attr = (cmd_ff.kind == CSCS_ATTR_RD) || (cmd_ff.kind == CSCS_ATTR_WR);
    is_dma = (cmd_ff.kind == CSCS_DMA_RD) || (cmd_ff.kind == CSCS_DMA_WR);
    is_rd = (cmd_ff.kind == CSCS_CMEM_RD) || (cmd_ff.kind == CSCS_ATTR_RD) ||
            (cmd_ff.kind == CSCS_IO_RD) || (cmd_ff.kind == CSCS_DMA_RD);
    hi_byte = cmd_ff.wdata[15:8];
    lo_byte = cmd_ff.wdata[7:0];
    want_hi = 1'b0;
    want_lo = 1'b0;
    unique case (cmd_ff.width)
      CSCS_BYTE: begin
        want_lo = 1'b1;
      end
      CSCS_WORD: begin
        want_hi = 1'b1;
        want_lo = 1'b1;
      end
      CSCS_ODD, CSCS_RSVD: begin
        // DMA has no odd-only form; it falls back to a low-lane byte
        want_hi = !is_dma;
        want_lo = is_dma;
      end
    endcase
  end

  // ************************************************
  // Cycle sequencer
  // ************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_cnt = cnt_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    nxt_busy = busy_ff;
    nxt_sel = sel_ff;
    nxt_ceh = ceh_ff;
    nxt_cel = cel_ff;
    nxt_lsb = lsb_ff;
    nxt_mrd = mrd_ff;
    nxt_mwr = mwr_ff;
    nxt_iord = iord_ff;
    nxt_iowr = iowr_ff;
    nxt_dma_grant = dma_grant_ff;
    nxt_hout = hout_ff;
    nxt_hoe = hoe_ff;
    nxt_lout = lout_ff;
    nxt_loe = loe_ff;
    unique case (state_ff)
      CSCS_IDLE: begin
        nxt_busy = 1'b0;
        if (q_if.valid) begin
          nxt_cmd = q_cmd;
          nxt_state = CSCS_SETUP;
          nxt_cnt = '0;
          nxt_busy = 1'b1;
        end
      end
      CSCS_SETUP: begin
        // Other socket stays at its idle levels
        nxt_sel = SOCK_IDLE;
        nxt_ceh = SOCK_IDLE;
        nxt_cel = SOCK_IDLE;
        // Space select: high for common memory, low for I/O and attribute
        nxt_sel[cmd_ff.socket] = !(is_io || is_attr);
        nxt_ceh[cmd_ff.socket] = !want_hi;
        nxt_cel[cmd_ff.socket] = !want_lo;
        nxt_lsb = (cmd_ff.width == CSCS_BYTE) ? cmd_ff.lsb : 1'b0;
        nxt_dma_grant = is_dma;
        nxt_hoe = 1'b0;
        nxt_loe = 1'b0;
        if (!is_rd) begin
          // Addressed byte goes on the low lane for byte writes
          nxt_lout = (cmd_ff.width == CSCS_BYTE && cmd_ff.lsb && !is_dma) ? hi_byte : lo_byte;
          nxt_hout = hi_byte;
          // Attribute space carries only even bytes, so the high lane stays off
          nxt_loe = want_lo;
          nxt_hoe = want_hi && !is_attr;
        end
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff + 4'h1 >= SETUP_CYC) begin
          nxt_state = CSCS_ACTIVE;
          nxt_cnt = '0;
          unique case (cmd_ff.kind)
            CSCS_CMEM_RD, CSCS_ATTR_RD: nxt_mrd = 1'b0;
            CSCS_CMEM_WR, CSCS_ATTR_WR: nxt_mwr = 1'b0;
            CSCS_IO_RD: nxt_iord = 1'b0;
            CSCS_IO_WR: nxt_iowr = 1'b0;
            CSCS_DMA_RD: begin
              nxt_iowr = 1'b0;
              nxt_mwr = cmd_ff.tc;
            end
            CSCS_DMA_WR: begin
              nxt_iord = 1'b0;
              nxt_mrd = cmd_ff.tc;
            end
          endcase
        end
      end
      CSCS_ACTIVE: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff + 4'h1 >= ACTIVE_CYC) begin
          nxt_state = CSCS_RECOVER;
          nxt_cnt = '0;
          nxt_mrd = 1'b1;
          nxt_mwr = 1'b1;
          nxt_iord = 1'b1;
          nxt_iowr = 1'b1;
          if (is_rd) begin
            nxt_rsp_valid = 1'b1;
            if (is_attr) begin
              nxt_rsp_data = {8'h00, low_data_lane_in};
            end else if (want_hi && want_lo) begin
              nxt_rsp_data = {high_data_lane_in, low_data_lane_in};
            end else if (want_hi) begin
              nxt_rsp_data = {high_data_lane_in, 8'h00};
            end else if (cmd_ff.lsb && !is_dma) begin
              nxt_rsp_data = {low_data_lane_in, 8'h00};
            end else begin
              nxt_rsp_data = {8'h00, low_data_lane_in};
            end
          end
        end
      end
      CSCS_RECOVER: begin
        // Lanes are released on the same edge the enables return to idle, one cycle after the strobes end
        nxt_hoe = 1'b0;
        nxt_loe = 1'b0;
        nxt_sel = SOCK_IDLE;
        nxt_ceh = SOCK_IDLE;
        nxt_cel = SOCK_IDLE;
        nxt_dma_grant = 1'b0;
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff + 4'h1 >= RECOVER_CYC) begin
          nxt_state = CSCS_IDLE;
          nxt_cnt = '0;
          nxt_busy = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= CSCS_IDLE;
      cmd_ff <= '0;
      cnt_ff <= '0;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= DATA_RST;
      busy_ff <= 1'b0;
      sel_ff <= SOCK_IDLE;
      ceh_ff <= SOCK_IDLE;
      cel_ff <= SOCK_IDLE;
      lsb_ff <= 1'b0;
      mrd_ff <= 1'b1;
      mwr_ff <= 1'b1;
      iord_ff <= 1'b1;
      iowr_ff <= 1'b1;
      dma_grant_ff <= 1'b0;
      hout_ff <= 8'h00;
      hoe_ff <= 1'b0;
      lout_ff <= 8'h00;
      loe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      cnt_ff <= nxt_cnt;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      busy_ff <= nxt_busy;
      sel_ff <= nxt_sel;
      ceh_ff <= nxt_ceh;
      cel_ff <= nxt_cel;
      lsb_ff <= nxt_lsb;
      mrd_ff <= nxt_mrd;
      mwr_ff <= nxt_mwr;
      iord_ff <= nxt_iord;
      iowr_ff <= nxt_iowr;
      dma_grant_ff <= nxt_dma_grant;
      hout_ff <= nxt_hout;
      hoe_ff <= nxt_hoe;
      lout_ff <= nxt_lout;
      loe_ff <= nxt_loe;
    end
  end

  // ************************************************
  // Pin drive
  // ************************************************
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign busy = busy_ff;
  assign space_select = sel_ff;
  assign high_lane_card_enable_n = ceh_ff;
  assign low_lane_card_enable_n = cel_ff;
  assign address_lsb = lsb_ff;
  assign mem_read_strobe_n = mrd_ff;
  assign mem_write_strobe_n = mwr_ff;
  assign io_read_strobe_n = iord_ff;
  assign io_write_strobe_n = iowr_ff;
  assign dma_grant = dma_grant_ff;
  assign high_data_lane_out = hout_ff;
  assign high_data_lane_oe = hoe_ff;
  assign low_data_lane_out = lout_ff;
  assign low_data_lane_oe = loe_ff;

endmodule

// ==== test/cscs_card_model.sv ====
// Purpose: Card in either socket answering reads on its enabled lanes, low lane only for attribute
// Assumes: One fixed data word per socket
// Notes: Lanes not driven show changing junk
`timescale 1ns/1ps

module cscs_card_model #(
  parameter logic [15:0] CARD0 = 16'hc33c,
  parameter logic [15:0] CARD1 = 16'h9669
) (
  input wire logic clk,
  input wire logic [1:0] space_select,
  input wire logic [1:0] high_lane_card_enable_n,
  input wire logic [1:0] low_lane_card_enable_n,
  input wire logic address_lsb,
  input wire logic mem_read_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic dma_grant,
  output logic [7:0] high_data_lane,
  output logic [7:0] low_data_lane
);
  logic s;
  logic rd;
  logic attr;
  logic hd;
  logic ld;
  logic [15:0] w;
  logic [7:0] lv;
  logic [7:0] hi_q = 8'h00;
  logic [7:0] lo_q = 8'h00;
  assign s = !(high_lane_card_enable_n[1] && low_lane_card_enable_n[1]);
  assign w = s ? CARD1 : CARD0;
  assign attr = !space_select[s] && !mem_read_strobe_n;
  // A DMA read moves card data out on the I/O write strobe
  assign rd = dma_grant ? !io_write_strobe_n : !(mem_read_strobe_n && io_read_strobe_n);
  assign hd = rd && !high_lane_card_enable_n[s] && !attr;
  assign ld = rd && !low_lane_card_enable_n[s];
  assign lv = (high_lane_card_enable_n[s] && address_lsb && !attr) ? w[15:8] : w[7:0];
  // Released lanes toggle so a late sample cannot match by luck
  assign high_data_lane = hd ? w[15:8] : ~hi_q;
  assign low_data_lane = ld ? lv : ~lo_q;
  always @(posedge clk) begin
    hi_q <= high_data_lane;
    lo_q <= low_data_lane;
  end
endmodule

// ==== test/cscs_host_sva.sv ====
// Purpose: Port checks for the card socket cycle engine
// Assumes: One clock, synchronous active-low reset
// Notes: Ten-cycle strobe matches the active phase count
`timescale 1ns/1ps

module cscs_host_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rsp_valid,
  input wire logic [1:0] space_select,
  input wire logic [1:0] high_lane_card_enable_n,
  input wire logic [1:0] low_lane_card_enable_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic dma_grant,
  input wire logic high_data_lane_oe,
  input wire logic low_data_lane_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ****************
  // Checks
  // ****************
  property p_one_sock;
    (high_lane_card_enable_n & low_lane_card_enable_n) != 2'h0 && space_select != 2'h0;
  endproperty
  a_one_sock: assert property (p_one_sock) else $error("two sockets active");
  property p_rd_len;
    $fell(mem_read_strobe_n) |-> !mem_read_strobe_n [*8] ##1 !mem_read_strobe_n [*2]
      ##1 mem_read_strobe_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length");
  property p_rsp;
    rsp_valid |-> $rose(mem_read_strobe_n) || $rose(io_read_strobe_n) || $rose(io_write_strobe_n);
  endproperty
  a_rsp: assert property (p_rsp) else $error("read answer off strobe end");
  property p_rd_float;
    (!mem_read_strobe_n || !io_read_strobe_n) && !dma_grant |-> !high_data_lane_oe
      && !low_data_lane_oe;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("lane driven in read");
  property p_cm_wr;
    !mem_write_strobe_n && !dma_grant && space_select == 2'h3 |->
      high_data_lane_oe == (high_lane_card_enable_n != 2'h3)
      && low_data_lane_oe == (low_lane_card_enable_n != 2'h3);
  endproperty
  a_cm_wr: assert property (p_cm_wr) else $error("write lanes off enables");
  property p_io_sel;
    (!io_read_strobe_n || !io_write_strobe_n) && !dma_grant |-> space_select != 2'h3
      && mem_read_strobe_n && mem_write_strobe_n;
  endproperty
  a_io_sel: assert property (p_io_sel) else $error("io cycle select");
  property p_io_lead;
    $fell(io_write_strobe_n) && !dma_grant |-> $past(space_select) != 2'h3;
  endproperty
  a_io_lead: assert property (p_io_lead) else $error("io write before select");
  property p_dma_rd;
    dma_grant && !io_write_strobe_n |-> mem_read_strobe_n && io_read_strobe_n;
  endproperty
  a_dma_rd: assert property (p_dma_rd) else $error("dma read strobes");
  property p_dma_wr;
    dma_grant && !io_read_strobe_n |-> mem_write_strobe_n && io_write_strobe_n;
  endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("dma write strobes");
  property p_attr;
    space_select != 2'h3 && !mem_write_strobe_n |-> !high_data_lane_oe;
  endproperty
  a_attr: assert property (p_attr) else $error("attribute high lane driven");
endmodule

bind cscs_socket_host cscs_host_sva u_sva (.clk(clk), .resetn(resetn), .rsp_valid(rsp_valid),
  .space_select(space_select), .high_lane_card_enable_n(high_lane_card_enable_n),
  .low_lane_card_enable_n(low_lane_card_enable_n), .mem_read_strobe_n(mem_read_strobe_n),
  .mem_write_strobe_n(mem_write_strobe_n), .io_read_strobe_n(io_read_strobe_n),
  .io_write_strobe_n(io_write_strobe_n), .dma_grant(dma_grant),
  .high_data_lane_oe(high_data_lane_oe), .low_data_lane_oe(low_data_lane_oe));

// ==== test/cscs_socket_host_tb_top.sv ====
// Purpose: Self-checking bench for the card socket cycle engine
// Assumes: Card model answers reads; inputs change at falling edges
// Notes: Expected pins are worked out from the cycle tables
`timescale 1ns/1ps

module cscs_socket_host_tb_top;
  import cscs_pkg::*;
  localparam logic [15:0] CARD0 = 16'hc33c;
  localparam logic [15:0] CARD1 = 16'h9669;
  localparam logic [15:0] WD = 16'h5ac3;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  cscs_kind_t req_kind = CSCS_CMEM_RD;
  cscs_width_t req_width = CSCS_BYTE;
  logic req_socket = 1'b0;
  logic req_lsb = 1'b0;
  logic req_tc = 1'b0;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic busy;
  logic busy_q = 1'b0;
  logic [1:0] space_select;
  logic [1:0] hen;
  logic [1:0] len;
  logic address_lsb;
  logic mrs;
  logic mws;
  logic irs;
  logic iws;
  logic dma_grant;
  logic [7:0] hin;
  logic [7:0] hout;
  logic [7:0] lin;
  logic [7:0] lout;
  logic hoe;
  logic loe;
  logic [13:0] pins;
  logic [13:0] g_pins;
  logic [15:0] g_dout;
  logic [15:0] g_rsp;
  int g_nrsp;
  int n_fail = 0;
  int n_compared = 0;
  int n_cyc = 0;
  assign pins = {space_select, hen, len, address_lsb, mrs, mws, irs, iws, dma_grant, hoe, loe};
  always #2 clk = ~clk;
  always @(negedge clk) begin
    if (busy === 1'b1 && busy_q === 1'b0) begin
      n_cyc++;
    end
    busy_q = busy;
  end
  cscs_socket_host dut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_kind(req_kind), .req_width(req_width), .req_socket(req_socket), .req_lsb(req_lsb),
    .req_tc(req_tc), .req_wdata(WD), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
    .space_select(space_select), .high_lane_card_enable_n(hen), .low_lane_card_enable_n(len),
    .address_lsb(address_lsb), .mem_read_strobe_n(mrs), .mem_write_strobe_n(mws),
    .io_read_strobe_n(irs), .io_write_strobe_n(iws), .dma_grant(dma_grant),
    .high_data_lane_in(hin), .high_data_lane_out(hout), .high_data_lane_oe(hoe),
    .low_data_lane_in(lin), .low_data_lane_out(lout), .low_data_lane_oe(loe));
  cscs_card_model #(.CARD0(CARD0), .CARD1(CARD1)) card (.clk(clk), .space_select(space_select),
    .high_lane_card_enable_n(hen), .low_lane_card_enable_n(len), .address_lsb(address_lsb),
    .mem_read_strobe_n(mrs), .io_read_strobe_n(irs), .io_write_strobe_n(iws),
    .dma_grant(dma_grant), .high_data_lane(hin), .low_data_lane(lin));
  function automatic logic [13:0] pexp(input logic [2:0] k, input cscs_width_t w, input logic s,
      input logic l, input logic tc);
    logic [1:0] sel;
    logic [1:0] he;
    logic [1:0] le;
    logic dma;
    logic by;
    dma = k[2] && k[1];
    by = (w == CSCS_BYTE) || (dma && w != CSCS_WORD);
    sel = 2'h3;
    he = 2'h3;
    le = 2'h3;
    sel[s] = ~(k[2] ^ k[1]);
    he[s] = by;
    le[s] = !by && w != CSCS_WORD;
    return {sel, he, le, (w == CSCS_BYTE) & l, (k == 3'h7) ? tc : (k[2] || k[0]),
      (k == 3'h6) ? tc : (k[2] || !k[0]), k != 3'h4 && k != 3'h7, k != 3'h5 && k != 3'h6,
      dma, k[0] && !he[s] && k[2:1] != 2'h1, k[0] && !le[s]};
  endfunction
  function automatic logic [15:0] rexp(input logic [2:0] k, input cscs_width_t w, input logic s,
      input logic l);
    logic [15:0] c;
    c = s ? CARD1 : CARD0;
    if (w == CSCS_WORD && k[2:1] != 2'h1) return c;
    if (k[2:1] == 2'h1 || k[2:1] == 2'h3 || (w == CSCS_BYTE && !l)) return {8'h00, c[7:0]};
    return {c[15:8], 8'h00};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask
  // One whole card cycle; the pins are caught in the last cycle of the strobe
  task run(input cscs_kind_t k, input cscs_width_t w, input logic s, input logic l,
      input logic tc);
    int n;
    logic [2:0] kb;
    logic [13:0] pe;
    logic [15:0] dm;
    @(negedge clk);
    req_kind = k;
    req_width = w;
    req_socket = s;
    req_lsb = l;
    req_tc = tc;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    {g_nrsp, g_pins, n, kb} = {32'h0, 14'h0, 32'h0, k};
    while ((n < 8 || busy !== 1'b0) && n < 80) begin
      @(negedge clk);
      n++;
      if ((mrs && mws && irs && iws) === 1'b0) begin
        g_pins = pins;
        g_dout = {hout, lout};
      end
      if (rsp_valid === 1'b1) begin
        g_nrsp++;
        g_rsp = rsp_data;
      end
    end
    pe = pexp(k, w, s, l, tc);
    dm = {{8{pe[1]}}, {8{pe[0]}}};
    chk(16'(g_pins), 16'(pe));
    chk(g_dout & dm, {WD[15:8], pe[7] ? WD[15:8] : WD[7:0]} & dm);
    // Back at idle levels once busy drops; a hung cycle fails here
    chk({busy, 1'b0, pins} & 16'hbf7f, 16'h3f78);
    chk(16'(g_nrsp), 16'(!kb[0]));
    if (!kb[0]) chk(g_rsp, rexp(k, w, s, l));
  endtask
  task sweep(input cscs_kind_t k);
    for (int s = 0; s < 2; s++) begin
      run(k, CSCS_BYTE, s[0], 1'b0, 1'b0);
      run(k, CSCS_BYTE, s[0], 1'b1, 1'b0);
      run(k, CSCS_WORD, s[0], 1'b0, 1'b0);
      run(k, CSCS_ODD, s[0], 1'b1, 1'b0);
    end
  endtask
  task t_cmem;
    sweep(CSCS_CMEM_RD);
    sweep(CSCS_CMEM_WR);
    run(CSCS_CMEM_RD, CSCS_RSVD, 1'b1, 1'b0, 1'b0);
  endtask
  task t_io;
    sweep(CSCS_IO_RD);
    sweep(CSCS_IO_WR);
  endtask
  task t_attr;
    for (int s = 0; s < 2; s++) begin
      run(CSCS_ATTR_RD, CSCS_BYTE, s[0], 1'b0, 1'b0);
      run(CSCS_ATTR_RD, CSCS_WORD, s[0], 1'b0, 1'b0);
      run(CSCS_ATTR_WR, CSCS_WORD, s[0], 1'b0, 1'b0);
      run(CSCS_ATTR_WR, CSCS_ODD, s[0], 1'b0, 1'b0);
    end
  endtask
  task t_dma;
    for (int t = 0; t < 4; t++) begin
      run(CSCS_DMA_RD, t[1] ? CSCS_WORD : CSCS_BYTE, t[0], 1'b0, t[0]);
      run(CSCS_DMA_WR, t[1] ? CSCS_WORD : CSCS_ODD, t[0], 1'b0, t[0]);
    end
  endtask
  // Fill the queue until refused, then drain: every taken command runs once
  task t_queue;
    int p;
    int c0;
    int n;
    {p, n, c0} = {32'h0, 32'h0, n_cyc};
    @(negedge clk);
    req_kind = CSCS_CMEM_WR;
    req_width = CSCS_WORD;
    req_socket = 1'b0;
    req_valid = 1'b1;
    while (req_ready === 1'b1 && p < 40) begin
      @(negedge clk);
      p++;
    end
    req_valid = 1'b0;
    chk(16'(p >= FIFO_DEPTH), 16'h1);
    while ((n_cyc - c0 < p || busy !== 1'b0) && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n_cyc - c0), 16'(p));
  endtask
  task stop_test;
    $display("Compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    chk(16'(pins), 16'h3f78);
    t_cmem;
    t_io;
    t_attr;
    t_dma;
    t_queue;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test;
  end
endmodule
